// ---- rsw_ctrl.sv ----
// Reset sequencer, software watchdog and clock-loss monitor with APB registers
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rsw_ctrl
  import rsw_pkg::*;
#(
  parameter int ECLK_DIV      = ECLK_DIV_DEF,
  parameter int CM_WINDOW     = CM_WINDOW_CYC,
  parameter bit WDDIS_DEFAULT = 1'b0
)
(
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire rsw_apb_req_t apb_i,
  output rsw_apb_rsp_t      apb_o,
  input  wire logic         special_mode_i,
  input  wire logic         osc_ready_i,
  input  wire logic         refclk_i,
  input  wire logic         rstpin_i,
  output logic              rstpin_o,
  output logic              rstpin_oe_o,
  output logic              cpu_hold_o,
  output logic              vec_fetch_o,
  output logic [15:0]       vec_addr_o,
  output rsw_cause_t        cause_o
);

  // ==========================================================================
  // Elaboration checks
  if (ECLK_DIV < 2) begin : g_chk_div
    $error("ECLK_DIV must be at least 2");
  end
  if (CM_WINDOW < 8) begin : g_chk_cm
    $error("CM_WINDOW too small");
  end

  localparam int DW = $clog2(ECLK_DIV);
  localparam int CW = $clog2(CM_WINDOW + 1);

  typedef enum logic [2:0] {
    ST_POR_WAIT,
    ST_DRIVE,
    ST_SETTLE,
    ST_HOLD,
    ST_VECTOR,
    ST_RUN
  } rsw_state_t;

  rsw_state_t  state_q;
  logic [2:0]  syn_q [4];
  logic [3:0]  lvl_q;
  logic        pin_lvl;
  logic        mode_lvl;
  logic        osc_lvl;
  logic        ref_lvl;
  logic        ref_prev_q;
  logic [DW-1:0] div_q;
  logic        e_tick;
  logic [11:0] por_cnt_q;
  logic [2:0]  ecnt_q;
  logic [6:0]  opt_cnt_q;
  logic        opt_locked_q;
  logic        cfg_written_q;
  logic        mode_q;
  logic [1:0]  rate_q;
  logic        force_q;
  logic        enable_q;
  logic [7:0]  system_options_second_q;
  logic        wddis_q;
  logic        inhibit_q;
  logic        armed_q;
  logic [20:0] wd_cnt_q;
  logic [CW-1:0] cm_cnt_q;
  logic        ctl_clr;
  logic        cm_on;
  logic        clk_alive;
  logic        cm_loss;
  logic        wd_run;
  logic        wd_exp;
  logic        trig;
  rsw_cause_t  trig_cause;
  logic        bus_wr;
  logic        bus_rd;
  logic        opt_wr_ok;
  logic [7:0]  wbyte;
  logic [31:0] rdata;
  logic        mapped;

  // ==========================================================================
  // Pin synchronisers
  // Level updates only when second and third stages agree
  // Oscillator and mode stages reset low so a dead oscillator is never seen as running
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge mclk_i)
    begin
      if (rst_i)
      begin
        syn_q[g] <= (g == 0 || g == 2) ? 3'b111 : 3'b000;
        lvl_q[g] <= (g == 0 || g == 2);
      end
      else
      begin
        syn_q[g] <= {syn_q[g][1:0], (g == 0) ? rstpin_i : (g == 1) ? osc_ready_i
                                    : (g == 2) ? refclk_i : special_mode_i};
        if (syn_q[g][1] == syn_q[g][2])
          lvl_q[g] <= syn_q[g][2];
      end
    end
  end
  assign pin_lvl = lvl_q[0];
  assign osc_lvl = lvl_q[1];
  assign ref_lvl = lvl_q[2];
  assign mode_lvl = lvl_q[3];

  // ==========================================================================
  // E-clock enable divider
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || div_q == DW'(ECLK_DIV - 1))
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end
  assign e_tick = (div_q == DW'(ECLK_DIV - 1));

  // ==========================================================================
  // Derived conditions
  assign ctl_clr   = (state_q != ST_RUN) && (state_q != ST_VECTOR);
  assign cm_on     = enable_q || force_q;
  assign clk_alive = (cm_cnt_q < CW'(CM_WINDOW));
  assign cm_loss   = cm_on && !clk_alive;
  assign wd_run    = !wddis_q && !inhibit_q;
  assign wd_exp    = wd_run && e_tick && clk_alive
                     && (wd_cnt_q == rsw_wdog_limit(rate_q));
  assign trig      = (state_q == ST_RUN) && (!pin_lvl || cm_loss || wd_exp);
  assign trig_cause = !pin_lvl ? CAUSE_EXT : cm_loss ? CAUSE_CLK : CAUSE_WDOG;

  // ==========================================================================
  // Reset sequencer
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_q   <= ST_POR_WAIT;
      por_cnt_q <= '0;
      ecnt_q    <= '0;
      cause_o   <= CAUSE_POR;
    end
    else
    begin
      case (state_q)
        ST_POR_WAIT:
        begin
          if (osc_lvl)
            por_cnt_q <= por_cnt_q + 1'b1;
          if (osc_lvl && por_cnt_q == 12'(POR_DELAY_CYC - 1))
          begin
            state_q <= ST_DRIVE;
            ecnt_q  <= '0;
          end
        end
        ST_DRIVE:
        begin
          if (e_tick)
            ecnt_q <= ecnt_q + 1'b1;
          if (e_tick && ecnt_q == 3'(DRIVE_ECYC - 1))
          begin
            state_q <= ST_SETTLE;
            ecnt_q  <= '0;
          end
        end
        ST_SETTLE:
        begin
          if (e_tick)
            ecnt_q <= ecnt_q + 1'b1;
          if (e_tick && ecnt_q == 3'(SETTLE_ECYC - 1))
          begin
            if (!pin_lvl)
            begin
              state_q <= ST_HOLD;
              if (cause_o != CAUSE_POR)
                cause_o <= CAUSE_EXT;
            end
            else
              state_q <= ST_VECTOR;
          end
        end
        ST_HOLD:
        begin
          // Held for as long as the pin is low
          if (pin_lvl)
            state_q <= ST_VECTOR;
        end
        ST_VECTOR:
          state_q <= ST_RUN;
        ST_RUN:
        begin
          if (trig)
          begin
            state_q <= ST_DRIVE;
            ecnt_q  <= '0;
            cause_o <= trig_cause;
          end
        end
        default:
          state_q <= ST_POR_WAIT;
      endcase
    end
  end

  // ==========================================================================
  // Pin drive and CPU side outputs
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rstpin_o    <= 1'b0;
      rstpin_oe_o <= 1'b0;
      cpu_hold_o  <= 1'b1;
      vec_fetch_o <= 1'b0;
      vec_addr_o  <= 16'hfffe;
    end
    else
    begin
      rstpin_o    <= 1'b0;
      rstpin_oe_o <= (state_q == ST_DRIVE)
                     || ((state_q == ST_POR_WAIT) && osc_lvl
                         && por_cnt_q == 12'(POR_DELAY_CYC - 1))
                     || trig;
      cpu_hold_o  <= (state_q != ST_VECTOR) || trig;
      vec_fetch_o <= (state_q == ST_VECTOR);
      if (state_q == ST_VECTOR)
        vec_addr_o <= rsw_vector(cause_o, mode_q);
    end
  end

  // ==========================================================================
  // Clock-loss monitor
  // Window counter keeps running while disabled so enabling is clean
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ref_prev_q <= 1'b1;
      cm_cnt_q   <= '0;
    end
    else
    begin
      ref_prev_q <= ref_lvl;
      if (ref_lvl != ref_prev_q)
        cm_cnt_q <= '0;
      else if (cm_cnt_q != CW'(CM_WINDOW))
        cm_cnt_q <= cm_cnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // APB decode
  assign bus_wr    = apb_i.psel && apb_i.penable && apb_i.pwrite && apb_o.pready;
  assign bus_rd    = apb_i.psel && apb_i.penable && !apb_i.pwrite && !apb_o.pready;
  assign wbyte     = apb_i.pwdata[7:0];
  assign opt_wr_ok = mode_q || !opt_locked_q;

  always_comb
  begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (apb_i.paddr)
      OFS_OPTIONS:  rdata = {28'h0, enable_q, force_q, rate_q};
      OFS_OPTIONS2: rdata = {24'h0, system_options_second_q};
      OFS_SERVICE:  rdata = 32'h0000_0000;
      OFS_CONFIG:   rdata = {31'h0, wddis_q};
      OFS_TEST:     rdata = {31'h0, inhibit_q};
      OFS_STATUS:   rdata = {26'h0, armed_q, opt_locked_q, mode_q, state_q == ST_RUN, cause_o};
      default:      mapped = 1'b0;
    endcase
  end

  // One wait state; error on unmapped addresses
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      apb_o <= '0;
    else
    begin
      apb_o.pready  <= apb_i.psel && apb_i.penable && !apb_o.pready;
      apb_o.pslverr <= apb_i.psel && apb_i.penable && !apb_o.pready && !mapped;
      if (bus_rd)
        apb_o.prdata <= rdata;
    end
  end

  // ==========================================================================
  // Option registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || ctl_clr)
    begin
      rate_q       <= 2'b00;
      force_q      <= 1'b0;
      enable_q     <= 1'b0;
      system_options_second_q       <= SYSTEM_OPTIONS_SECOND_RESET;
      opt_locked_q <= 1'b0;
      opt_cnt_q    <= '0;
      mode_q       <= mode_lvl;
    end
    else
    begin
      if (e_tick && !opt_locked_q)
        opt_cnt_q <= opt_cnt_q + 1'b1;
      if (e_tick && opt_cnt_q == 7'(OPT_WINDOW_ECYC - 1))
        opt_locked_q <= 1'b1;
      if (bus_wr && apb_i.paddr == OFS_OPTIONS)
      begin
        enable_q <= wbyte[OPT_ENABLE_BIT];
        if (opt_wr_ok)
        begin
          rate_q       <= wbyte[OPT_RATE_LSB +: 2];
          opt_locked_q <= 1'b1;
          // Force can only be set; it drops at the next reset
          if (wbyte[OPT_FORCE_BIT])
            force_q <= 1'b1;
        end
      end
      if (bus_wr && apb_i.paddr == OFS_OPTIONS2)
        system_options_second_q <= wbyte;
    end
  end

  // ==========================================================================
  // Watchdog disable and test inhibit
  // Disable bit is kept across internal resets, only power-up restores it
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      wddis_q <= WDDIS_DEFAULT;
    else if (bus_wr && apb_i.paddr == OFS_CONFIG && !ctl_clr && (mode_q || !cfg_written_q))
      wddis_q <= wbyte[CFG_WDDIS_BIT];
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || ctl_clr)
    begin
      cfg_written_q <= 1'b0;
      inhibit_q     <= mode_lvl;
    end
    else
    begin
      if (bus_wr && apb_i.paddr == OFS_CONFIG)
        cfg_written_q <= 1'b1;
      if (bus_wr && apb_i.paddr == OFS_TEST && mode_q)
        inhibit_q <= wbyte[TST_INHIBIT_BIT];
    end
  end

  // ==========================================================================
  // Watchdog counter and service sequence
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || ctl_clr)
    begin
      wd_cnt_q <= '0;
      armed_q  <= 1'b0;
    end
    else
    begin
      if (bus_wr && apb_i.paddr == OFS_SERVICE && wbyte == SERVICE_ARM)
        armed_q <= 1'b1;
      else if (bus_wr && apb_i.paddr == OFS_SERVICE && wbyte == SERVICE_CLEAR)
        armed_q <= 1'b0;
      if (bus_wr && apb_i.paddr == OFS_SERVICE && wbyte == SERVICE_CLEAR && armed_q)
        wd_cnt_q <= '0;
      else if (wd_run && e_tick && clk_alive)
        wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  hold_on_trig_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    trig |=> cpu_hold_o && (state_q == ST_DRIVE))
    else $error("reset trigger did not hold the CPU");

  vector_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    vec_fetch_o |-> vec_addr_o == rsw_vector(cause_o, mode_q))
    else $error("restart vector does not match cause and mode");

  fetch_soon_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(cpu_hold_o) |-> ##[0:2] vec_fetch_o)
    else $error("vector fetch missing after reset release");

  por_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_POR_WAIT && por_cnt_q < 12'(POR_DELAY_CYC - 1)) |=>
      state_q == ST_POR_WAIT && !rstpin_oe_o)
    else $error("power-up delay cut short");

  drive_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_DRIVE && e_tick && ecnt_q == 3'(DRIVE_ECYC - 1)) |=>
      state_q == ST_SETTLE ##1 !rstpin_oe_o)
    else $error("pin drive phase wrong length");

  ext_class_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_SETTLE && e_tick && ecnt_q == 3'(SETTLE_ECYC - 1) && !pin_lvl
     && cause_o != CAUSE_POR) |=> cause_o == CAUSE_EXT && state_q == ST_HOLD)
    else $error("external reset not recognised");

  wdog_fire_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_RUN && wd_exp && pin_lvl && !cm_loss) |=>
      cpu_hold_o && cause_o == CAUSE_WDOG)
    else $error("watchdog expiry did not reset");

  opt_lock_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!mode_q && opt_locked_q && !ctl_clr) |=> $stable(rate_q))
    else $error("locked rate select changed");

  force_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (force_q && !ctl_clr) |=> force_q || ctl_clr)
    else $error("force dropped before reset");

  service_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (bus_wr && apb_i.paddr == OFS_SERVICE && wbyte == SERVICE_CLEAR && armed_q && !ctl_clr)
      |=> wd_cnt_q == 21'h0 && !armed_q)
    else $error("service sequence did not clear watchdog");

endmodule
`default_nettype wire

// ---- rsw_ctrl_test.sv ----
// Self-checking testbench for the reset source and watchdog unit
`timescale 1ns/1ps
`default_nettype none
module rsw_ctrl_test;
  import rsw_pkg::*;
  // Short monitor window keeps clock-loss runs brief
  localparam int CMW = 64;
  logic         mclk;
  logic         rst;
  rsw_apb_req_t req;
  rsw_apb_rsp_t rsp;
  logic         special;
  logic         osc_ok;
  logic         refclk;
  logic         ref_run;
  logic [1:0]   ref_div;
  logic         pin;
  logic         ext_low;
  logic         pin_o;
  logic         pin_oe;
  logic         hold;
  logic         vfetch;
  logic [15:0]  vaddr;
  rsw_cause_t   cause;
  int           failures;
  int           compares;
  int           oe_cnt;
  logic [31:0]  rd;
  logic         err;

  rsw_ctrl #(.CM_WINDOW(CMW)) rsw_ctrl_inst (.mclk_i(mclk), .rst_i(rst), .apb_i(req),
    .apb_o(rsp), .special_mode_i(special), .osc_ready_i(osc_ok), .refclk_i(refclk),
    .rstpin_i(pin), .rstpin_o(pin_o), .rstpin_oe_o(pin_oe), .cpu_hold_o(hold),
    .vec_fetch_o(vfetch), .vec_addr_o(vaddr), .cause_o(cause));

  rsw_pin_model rsw_pin_model_inst (.dev_oe_i(pin_oe), .dev_val_i(pin_o),
    .ext_low_i(ext_low), .pin_o(pin));

  // ==========================================================================
  // Clocks
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Monitored clock at an eighth of mclk; stops when ref_run is low
  always @(posedge mclk)
  begin
    ref_div <= ref_div + 2'd1;
    if (ref_run && ref_div == 2'd3)
      refclk <= ~refclk;
    if (pin_oe)
      oe_cnt <= oe_cnt + 1;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for pready as long as it takes; only the hang guard ends a stuck transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge mclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  // Bounded wait for the restart vector pulse
  task automatic wait_vec();
    int n;
    n = 0;
    while (vfetch !== 1'b1 && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
    if (vfetch !== 1'b1)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, vfetch, 1'b1);
    end
  endtask

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_por();
    osc_ok <= 1'b1;
    repeat (4000) @(posedge mclk);
    chk(32'(hold), 32'h1);
    ext_low <= 1'b1;
    repeat (300) @(posedge mclk);
    chk(32'(hold), 32'h1);
    ext_low <= 1'b0;
    wait_vec();
    chk(32'(vaddr), 32'hfffe);
    chk(32'(cause), 32'(CAUSE_POR));
    chk(32'(hold), 32'h0);
    $display("test por done");
  endtask

  task automatic t_regs();
    apb(1'b0, OFS_OPTIONS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_OPTIONS2, 32'h0);
    chk(rd, 32'(SYSTEM_OPTIONS_SECOND_RESET));
    apb(1'b0, 8'h7c, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[2]), 32'h1);
    apb(1'b1, OFS_SERVICE, 32'h55);
    apb(1'b1, OFS_SERVICE, 32'h12);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[5]), 32'h1);
    apb(1'b1, OFS_SERVICE, 32'haa);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[5]), 32'h0);
    $display("test regs done");
  endtask

  task automatic t_once();
    apb(1'b1, OFS_OPTIONS, 32'h1);
    apb(1'b1, OFS_OPTIONS, 32'ha);
    apb(1'b0, OFS_OPTIONS, 32'h0);
    chk(rd, 32'h9);
    apb(1'b1, OFS_CONFIG, 32'h1);
    apb(1'b1, OFS_CONFIG, 32'h0);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[4]), 32'h1);
    $display("test write once done");
  endtask

  task automatic t_loss(input logic [31:0] opt, input logic [15:0] va);
    oe_cnt <= 0;
    apb(1'b1, OFS_OPTIONS, opt);
    apb(1'b1, OFS_SERVICE, 32'h55);
    ref_run <= 1'b0;
    wait_vec();
    ref_run <= 1'b1;
    chk(32'(vaddr), 32'(va));
    chk(32'(cause), 32'(CAUSE_CLK));
    chk(32'(oe_cnt >= 14 && oe_cnt <= 17), 32'h1);
    chk(32'(pin_o), 32'h0);
    apb(1'b0, OFS_OPTIONS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[5]), 32'h0);
    $display("test clock loss done");
  endtask

  task automatic t_ext(input logic sp, input logic [15:0] va);
    special <= sp;
    ext_low <= 1'b1;
    repeat (40) @(posedge mclk);
    ext_low <= 1'b0;
    wait_vec();
    chk(32'(vaddr), 32'(va));
    chk(32'(cause), 32'(CAUSE_EXT));
    $display("test external done");
  endtask

  task automatic t_special();
    apb(1'b0, OFS_TEST, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, OFS_TEST, 32'h0);
    apb(1'b0, OFS_TEST, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h0);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h1);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(rd, 32'h1);
    $display("test special done");
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    req = '0;
    special = 1'b0;
    osc_ok = 1'b0;
    refclk = 1'b0;
    ref_run = 1'b1;
    ref_div = 2'd0;
    ext_low = 1'b0;
    failures = 0;
    compares = 0;
    oe_cnt = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_por();
    t_regs();
    t_once();
    t_loss(32'h9, 16'hfffc);
    t_loss(32'h4, 16'hfffc);
    t_ext(1'b0, 16'hfffe);
    t_ext(1'b1, 16'hbffe);
    t_special();
    t_loss(32'h8, 16'hbffc);
    test_done();
  end

  // Hang guard, well past the expected run length
  initial
  begin
    #200000;
    failures++;
    test_done();
  end
endmodule
`default_nettype wire

// ---- rsw_pin_model.sv ----
// Open-drain reset pin with pull-up and an external reset source
`timescale 1ns/1ps
`default_nettype none
module rsw_pin_model
(
  input  wire logic dev_oe_i,
  input  wire logic dev_val_i,
  input  wire logic ext_low_i,
  output logic      pin_o
);
  // ==========================================================================
  // Wire level
  // Pull-up gives high only when no party pulls low
  assign pin_o = (dev_oe_i ? dev_val_i : 1'b1) & ~ext_low_i;
endmodule
`default_nettype wire

// ---- rsw_pkg.sv ----
// Constants, types and helpers for the reset source and watchdog unit
// Function
// - Any reset aborts the CPU at once and reinitialises control registers.
// - Restart vector depends on reset cause and normal versus special mode.
// - Restart vector is fetched within three clocks after reset ends.
// - Power-up waits 4064 clocks after oscillator start, then holds while pin low.
// - Any reset drives the pin low four E cycles, samples two later.
// - Pin low at sample means external reset, else watchdog or clock loss.
// - Free-running watchdog resets the system unless serviced before expiry.
// - Normal modes run the watchdog from reset unless watchdog_disable is set.
// - Special modes start with test_reset_inhibit set; writing zero allows resets.
// - Watchdog_disable register is write-once in normal modes, unlimited in special.
// - Watchdog timeout is E period times 2^15, 2^17, 2^19 or 2^21.
// - Reset clears watchdog_rate_select, giving the shortest timeout.
// - Normal modes allow one option write, only within 64 E cycles.
// - Watchdog restarts on write 55 then AA to the service register.
// - Watchdog stops counting while the clock is lost.
// - Enabled clock-loss monitor resets when no clock edge arrives in window.
// - Clock_check_enable is read/write any time and cleared by reset.
// - Clock_check_force holds the monitor enabled until the next reset.
// - Monitor window flags E below 10 kHz, never at or above 200 kHz.
package rsw_pkg;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0] OFS_OPTIONS  = 8'h30;
  localparam logic [7:0] OFS_OPTIONS2 = 8'h38;
  localparam logic [7:0] OFS_SERVICE  = 8'h3c;
  localparam logic [7:0] OFS_CONFIG   = 8'h40;
  localparam logic [7:0] OFS_TEST     = 8'h44;
  localparam logic [7:0] OFS_STATUS   = 8'h48;

  // ==========================================================================
  // Field positions and reset values
  localparam int         OPT_RATE_LSB    = 0;
  localparam int         OPT_FORCE_BIT   = 2;
  localparam int         OPT_ENABLE_BIT  = 3;
  localparam int         CFG_WDDIS_BIT   = 0;
  localparam int         TST_INHIBIT_BIT = 0;
  localparam logic [7:0] SYSTEM_OPTIONS_SECOND_RESET      = 8'h00;
  localparam logic [7:0] SERVICE_ARM     = 8'h55;
  localparam logic [7:0] SERVICE_CLEAR   = 8'haa;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ         = 250;
  localparam int POR_DELAY_CYC   = 4064;
  localparam int DRIVE_ECYC      = 4;
  localparam int SETTLE_ECYC     = 2;
  localparam int OPT_WINDOW_ECYC = 64;
  localparam int ECLK_DIV_DEF    = 4;
  // Window between 5 us (200 kHz) and 100 us (10 kHz) periods
  localparam int CM_WINDOW_NS    = 50000;
  localparam int CM_WINDOW_CYC   = CM_WINDOW_NS * CLK_MHZ / 1000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CAUSE_POR,
    CAUSE_EXT,
    CAUSE_CLK,
    CAUSE_WDOG
  } rsw_cause_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rsw_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rsw_apb_rsp_t;

  // ==========================================================================
  // Restart vector, high byte of the pair
  function automatic logic [15:0] rsw_vector(input rsw_cause_t c, input logic special);
    logic [15:0] v;
    v = special ? 16'hbffe : 16'hfffe;
    case (c)
      CAUSE_CLK:  v = special ? 16'hbffc : 16'hfffc;
      CAUSE_WDOG: v = special ? 16'hbffa : 16'hfffa;
      default:    v = special ? 16'hbffe : 16'hfffe;
    endcase
    return v;
  endfunction

  // Last count before watchdog expiry for a rate select value
  function automatic logic [20:0] rsw_wdog_limit(input logic [1:0] rate);
    logic [20:0] l;
    l = 21'h007fff;
    case (rate)
      2'b01:   l = 21'h01ffff;
      2'b10:   l = 21'h07ffff;
      2'b11:   l = 21'h1fffff;
      default: l = 21'h007fff;
    endcase
    return l;
  endfunction

endpackage
